//--- rtl/pbc_pkg.sv
// Package for the basic control and status register bank.
// Assumes a 5-bit register index and 16-bit register words from the management side.
package pbc_pkg;
    localparam int REG_COUNT = 32;
    localparam logic [4:0] BASIC_CONTROL_IDX = 5'h00;
    localparam logic [4:0] BASIC_STATUS_IDX = 5'h01;
    localparam logic [4:0] VENDOR_FIRST_IDX = 5'h10;
    // Control bit positions
    localparam int CTL_RESET_BIT = 15;
    localparam int CTL_LOOPBACK_BIT = 14;
    localparam int CTL_SPEED_BIT = 13;
    localparam int CTL_ANEG_EN_BIT = 12;
    localparam int CTL_PDOWN_BIT = 11;
    localparam int CTL_ISOLATE_BIT = 10;
    localparam int CTL_ANEG_RESTART_BIT = 9;
    localparam int CTL_DUPLEX_BIT = 8;
    localparam int CTL_COLTEST_BIT = 7;
    // Status word: T4 absent, all other modes capable, preamble suppression, extended regs
    localparam logic [15:0] STATUS_VALUE = 16'h7849;
    localparam logic LOOPBACK_RST = 1'b0;
    localparam logic PDOWN_RST = 1'b0;
    localparam logic COLTEST_RST = 1'b0;
endpackage : pbc_pkg

//--- rtl/pbc_regs.sv
// Basic control register and basic status register of a 10/100 transceiver.
// Assumes a management controller on the same clock supplying index, data and strobes.
// Function
// - Thirty-two register indices; only 0 and 1 are implemented, all others (upper sixteen vendor space) read zero.
// - Writing one to bit 15 resets the device; bit self-clears, reads zero.
// - Bits 14, 10, 7 select loopback, isolate, collision test.
// - Bit 13 picks 100 or 10 Mbps; ignored while auto-negotiation enabled.
// - Bit 12 enables auto-negotiation; its result overrides speed and duplex.
// - Bit 11 powers down; the first reset write only leaves power-down, a second one resets.
// - Writing one to bit 9 restarts auto-negotiation; bit self-clears.
// - Bit 8 selects full duplex; reset value is inverted duplex strap.
// - Speed, auto-negotiation enable and isolate load from straps at reset.
// - Status bit 15 reads zero, bit 14 reads one.
`timescale 1ns/1ps
module pbc_regs (
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] reg_index,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_hit,
    input wire logic speed_strap,
    input wire logic autoneg_enable_strap,
    input wire logic isolate_strap,
    input wire logic duplex_strap,
    input wire logic aneg_speed_100,
    input wire logic aneg_full_duplex,
    output logic soft_reset_pulse,
    output logic aneg_restart_pulse,
    output logic loopback,
    output logic isolate,
    output logic collision_test,
    output logic power_down,
    output logic autoneg_enable,
    output logic speed_100,
    output logic full_duplex
);
    // Strap pins gathered so one synchroniser loop serves them all
    localparam int STRAP_N = 4;
    wire [STRAP_N-1:0] strap_pins = {duplex_strap, isolate_strap, autoneg_enable_strap,
                                     speed_strap};
    wire [STRAP_N-1:0] strap_s_nxt;
    logic loop_r, speed_r, aneg_r, pdown_r, iso_r, dup_r, col_r;
    logic load_straps_r;
    logic [15:0] rdata_r;
    logic hit_r, srst_r, restart_r;
    logic out_speed_r, out_dup_r;
    // Named views of the filtered straps
    wire spd_s_nxt = strap_s_nxt[0];
    wire aneg_s_nxt = strap_s_nxt[1];
    wire iso_s_nxt = strap_s_nxt[2];
    wire dup_s_nxt = strap_s_nxt[3];

    // Three-stage synchroniser per strap; a level counts once stages 2 and 3 agree.
    // The filtered next value is what gets loaded, so a short reset cannot latch
    // a filter output that has not settled yet.
    genvar gi;
    generate
        for (gi = 0; gi < STRAP_N; gi++) begin : g_strap
            logic [2:0] sync_r;
            logic s_r;
            assign strap_s_nxt[gi] = (sync_r[2] == sync_r[1]) ? sync_r[2] : s_r;
            always_ff @(posedge clk) begin
                sync_r <= {sync_r[1:0], strap_pins[gi]};
                s_r <= strap_s_nxt[gi];
            end
        end
    endgenerate

    // Decode
    wire ctl_sel = (reg_index == pbc_pkg::BASIC_CONTROL_IDX);
    wire sts_sel = (reg_index == pbc_pkg::BASIC_STATUS_IDX);
    wire ctl_wr = reg_write && ctl_sel;
    wire wr_reset = ctl_wr && reg_wdata[pbc_pkg::CTL_RESET_BIT];
    // First reset write while powered down only leaves power-down
    wire reset_exit_pd = wr_reset && pdown_r;
    wire reset_real = wr_reset && !pdown_r;
    wire do_reset = reset || reset_real;
    // Control word as read back; self-clearing and reserved bits read zero
    wire [15:0] ctl_word = {1'b0, loop_r, speed_r, aneg_r, pdown_r, iso_r, 1'b0, dup_r,
                            col_r, 7'h00};
    wire [15:0] rd_mux = ctl_sel ? ctl_word :
                         sts_sel ? pbc_pkg::STATUS_VALUE : 16'h0000;
    // Negotiated result wins over manual speed and duplex
    wire eff_speed = aneg_r ? aneg_speed_100 : speed_r;
    wire eff_dup = aneg_r ? aneg_full_duplex : dup_r;

    // Control register; reset or software reset restores strap defaults
    // Straps load on the edge after reset; a write in that cycle is lost
    // Limitation: a strap moving within three cycles of reset may be missed
    always_ff @(posedge clk) begin
        load_straps_r <= do_reset;
        if (do_reset) begin
            loop_r <= pbc_pkg::LOOPBACK_RST;
            pdown_r <= pbc_pkg::PDOWN_RST;
            col_r <= pbc_pkg::COLTEST_RST;
            speed_r <= 1'b0;
            aneg_r <= 1'b0;
            iso_r <= 1'b0;
            dup_r <= 1'b0;
        end else if (load_straps_r) begin
            speed_r <= spd_s_nxt;
            aneg_r <= aneg_s_nxt;
            iso_r <= iso_s_nxt;
            dup_r <= !dup_s_nxt;
        end else if (reset_exit_pd) begin
            pdown_r <= 1'b0;
        end else if (ctl_wr) begin
            loop_r <= reg_wdata[pbc_pkg::CTL_LOOPBACK_BIT];
            speed_r <= reg_wdata[pbc_pkg::CTL_SPEED_BIT];
            aneg_r <= reg_wdata[pbc_pkg::CTL_ANEG_EN_BIT];
            pdown_r <= reg_wdata[pbc_pkg::CTL_PDOWN_BIT];
            iso_r <= reg_wdata[pbc_pkg::CTL_ISOLATE_BIT];
            dup_r <= reg_wdata[pbc_pkg::CTL_DUPLEX_BIT];
            col_r <= reg_wdata[pbc_pkg::CTL_COLTEST_BIT];
        end
    end

    // Read data, strobes and registered outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_r <= 16'h0000;
            hit_r <= 1'b0;
            srst_r <= 1'b0;
            restart_r <= 1'b0;
            out_speed_r <= 1'b0;
            out_dup_r <= 1'b0;
        end else begin
            rdata_r <= reg_read ? rd_mux : rdata_r;
            hit_r <= (reg_read || reg_write) && (ctl_sel || sts_sel);
            srst_r <= reset_real;
            restart_r <= ctl_wr && reg_wdata[pbc_pkg::CTL_ANEG_RESTART_BIT] && !reset_real;
            out_speed_r <= eff_speed;
            out_dup_r <= eff_dup;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_hit = hit_r;
    assign soft_reset_pulse = srst_r;
    assign aneg_restart_pulse = restart_r;
    assign loopback = loop_r;
    assign isolate = iso_r;
    assign collision_test = col_r;
    assign power_down = pdown_r;
    assign autoneg_enable = aneg_r;
    assign speed_100 = out_speed_r;
    assign full_duplex = out_dup_r;

    // Checks
    AST_RESET_READS_ZERO: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> !reg_rdata[15]) else $error("reset bit read nonzero");
    AST_SRST_PULSE: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && reg_wdata[15] && !power_down |=> soft_reset_pulse && !loopback)
        else $error("software reset missing");
    AST_PD_EXIT: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && reg_wdata[15] && power_down |=> !power_down && !soft_reset_pulse)
        else $error("power-down exit wrong");
    AST_LOOP_WRITE: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && !reg_wdata[15] && !load_straps_r |=> loopback == $past(reg_wdata[14]))
        else $error("loopback not written");
    AST_SPEED_ANEG: assert property (@(posedge clk) disable iff (reset)
        autoneg_enable |=> speed_100 == $past(aneg_speed_100))
        else $error("speed not overridden");
    AST_DUP_ANEG: assert property (@(posedge clk) disable iff (reset)
        autoneg_enable |=> full_duplex == $past(aneg_full_duplex))
        else $error("duplex not overridden");
    AST_RESTART: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && reg_wdata[9] && !reg_wdata[15] |=> aneg_restart_pulse)
        else $error("restart pulse missing");
    AST_RESTART_CLR: assert property (@(posedge clk) disable iff (reset)
        !(ctl_wr && reg_wdata[9]) |=> !aneg_restart_pulse)
        else $error("restart pulse not cleared");
    AST_DUP_STRAP: assert property (@(posedge clk) disable iff (reset)
        load_straps_r && !do_reset |=> ctl_word[8] == !$past(dup_s_nxt))
        else $error("duplex strap not inverted");
    AST_ANEG_STRAP: assert property (@(posedge clk) disable iff (reset)
        load_straps_r && !do_reset |=> autoneg_enable == $past(aneg_s_nxt) &&
        isolate == $past(iso_s_nxt))
        else $error("strap not loaded");
    AST_STATUS: assert property (@(posedge clk) disable iff (reset)
        reg_read && sts_sel |=> reg_rdata[15:14] == 2'b01)
        else $error("status capability wrong");
    AST_RESERVED: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> reg_rdata[6:0] == 7'h00)
        else $error("reserved bits nonzero");
    AST_VENDOR: assert property (@(posedge clk) disable iff (reset)
        reg_read && reg_index >= pbc_pkg::VENDOR_FIRST_IDX |=> reg_rdata == 16'h0000)
        else $error("vendor index not zero");

    // Write path: each writable bit lands one edge after the write
    AST_ISO_WRITE: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && !reg_wdata[15] && !load_straps_r |=> isolate == $past(reg_wdata[10]))
        else $error("isolate not written");
    AST_COL_WRITE: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && !reg_wdata[15] && !load_straps_r |=> collision_test == $past(reg_wdata[7]))
        else $error("collision test not written");
    AST_PD_WRITE: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && !reg_wdata[15] && !load_straps_r |=> power_down == $past(reg_wdata[11]))
        else $error("power-down not written");
    AST_ANEG_WRITE: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && !reg_wdata[15] && !load_straps_r |=> autoneg_enable == $past(reg_wdata[12]))
        else $error("autoneg enable not written");
    AST_SPEED_BIT: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && !reg_wdata[15] && !load_straps_r |=> speed_r == $past(reg_wdata[13]))
        else $error("speed bit not written");
    AST_DUP_BIT: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && !reg_wdata[15] && !load_straps_r |=> dup_r == $past(reg_wdata[8]))
        else $error("duplex bit not written");

    // Index decode: only index 0 takes writes, only 0 and 1 answer
    AST_OTHER_WRITE: assert property (@(posedge clk) disable iff (reset)
        reg_write && !ctl_sel && !load_straps_r |=> $stable(loopback) &&
        $stable(power_down) && $stable(isolate))
        else $error("write to other index took effect");
    AST_HIT_CTL: assert property (@(posedge clk) disable iff (reset)
        (reg_read || reg_write) && (ctl_sel || sts_sel) |=> reg_hit)
        else $error("hit missing");
    AST_HIT_OTHER: assert property (@(posedge clk) disable iff (reset)
        !((reg_read || reg_write) && (ctl_sel || sts_sel)) |=> !reg_hit)
        else $error("hit without access");
    AST_VENDOR_HIT: assert property (@(posedge clk) disable iff (reset)
        reg_read && reg_index >= pbc_pkg::VENDOR_FIRST_IDX |=> !reg_hit)
        else $error("vendor index hit");
    AST_OTHER_READ_ZERO: assert property (@(posedge clk) disable iff (reset)
        reg_read && !ctl_sel && !sts_sel |=> reg_rdata == 16'h0000)
        else $error("unmapped index not zero");
    AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (reset)
        !reg_read |=> $stable(reg_rdata))
        else $error("read data moved without read");

    // Software reset and its one-write exit from power-down
    AST_SRST_CLR: assert property (@(posedge clk) disable iff (reset)
        !(ctl_wr && reg_wdata[15]) |=> !soft_reset_pulse)
        else $error("reset pulse not cleared");
    AST_SRST_CLEARS: assert property (@(posedge clk) disable iff (reset)
        ctl_wr && reg_wdata[15] && !power_down |=> !power_down && !isolate &&
        !autoneg_enable && !collision_test)
        else $error("software reset left controls set");
    AST_SRST_NO_RESTART: assert property (@(posedge clk) disable iff (reset)
        reset_real |=> !aneg_restart_pulse)
        else $error("restart with software reset");
    AST_PD_EXIT_KEEP: assert property (@(posedge clk) disable iff (reset)
        reset_exit_pd |=> $stable(loopback) && $stable(isolate) &&
        $stable(collision_test) && $stable(autoneg_enable))
        else $error("power-down exit changed controls");
    AST_SRST_LOAD: assert property (@(posedge clk) disable iff (reset)
        reset_real |=> load_straps_r)
        else $error("software reset skipped strap load");
    AST_PD_NO_LOAD: assert property (@(posedge clk) disable iff (reset)
        reset_exit_pd |=> !load_straps_r)
        else $error("first reset write reloaded straps");
    AST_SRST_RESTRAP: assert property (@(posedge clk) disable iff (reset)
        soft_reset_pulse && !do_reset |=> isolate == $past(iso_s_nxt) &&
        autoneg_enable == $past(aneg_s_nxt))
        else $error("straps not relatched");

    // Strap defaults and effective mode
    AST_SPEED_STRAP: assert property (@(posedge clk) disable iff (reset)
        load_straps_r && !do_reset |=> speed_r == $past(spd_s_nxt))
        else $error("speed strap not loaded");
    AST_LOAD_ONCE: assert property (@(posedge clk) disable iff (reset)
        !do_reset |=> !load_straps_r)
        else $error("strap load without reset");
    AST_SPEED_MANUAL: assert property (@(posedge clk) disable iff (reset)
        !autoneg_enable |=> speed_100 == $past(speed_r))
        else $error("manual speed not used");
    AST_DUP_MANUAL: assert property (@(posedge clk) disable iff (reset)
        !autoneg_enable |=> full_duplex == $past(dup_r))
        else $error("manual duplex not used");

    // Read-back of control bits and fixed status word
    AST_LOOP_READ: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> reg_rdata[14] == $past(loopback))
        else $error("loopback read wrong");
    AST_ISO_READ: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> reg_rdata[10] == $past(isolate))
        else $error("isolate read wrong");
    AST_COL_READ: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> reg_rdata[7] == $past(collision_test))
        else $error("collision test read wrong");
    AST_PD_READ: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> reg_rdata[11] == $past(power_down))
        else $error("power-down read wrong");
    AST_ANEG_READ: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> reg_rdata[12] == $past(autoneg_enable))
        else $error("autoneg enable read wrong");
    AST_SPEED_READ: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> reg_rdata[13] == $past(speed_r))
        else $error("speed read wrong");
    AST_DUP_READ: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> reg_rdata[8] == $past(dup_r))
        else $error("duplex read wrong");
    AST_RESTART_READ: assert property (@(posedge clk) disable iff (reset)
        reg_read && ctl_sel |=> !reg_rdata[9])
        else $error("restart bit read nonzero");
    AST_RESERVED_WRITE: assert property (@(posedge clk) disable iff (reset)
        ctl_wr |=> ctl_word[6:0] == 7'h00)
        else $error("reserved bits took a write");
    AST_STATUS_WORD: assert property (@(posedge clk) disable iff (reset)
        reg_read && sts_sel |=> reg_rdata == pbc_pkg::STATUS_VALUE)
        else $error("status word wrong");
endmodule : pbc_regs

//--- sim/pbc_mgmt_model.sv
// Management controller model issuing single-word register strobes.
// Assumes the bank takes strobes on the rising edge of clk.
`timescale 1ns/1ps
module pbc_mgmt_model (
    input wire logic clk,
    output logic [4:0] reg_index,
    output logic reg_write,
    output logic reg_read,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_hit
);
    // Idle lines show inverted values so stale data cannot pass
    initial begin
        reg_index = 5'h1F;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 16'hFFFF;
    end
    // Write held through the taking edge, then released
    task automatic wr(input logic [4:0] idx, input logic [15:0] d);
        @(posedge clk);
        #1 reg_index = idx;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clk);
        #1 reg_write = 1'b0;
        reg_index = ~idx;
        reg_wdata = ~d;
    endtask : wr
    // Answer is registered at the taking edge
    task automatic rd(input logic [4:0] idx, output logic [15:0] d, output logic h);
        @(posedge clk);
        #1 reg_index = idx;
        reg_read = 1'b1;
        @(posedge clk);
        #1 reg_read = 1'b0;
        reg_index = ~idx;
        d = reg_rdata;
        h = reg_hit;
    endtask : rd
endmodule : pbc_mgmt_model

//--- sim/tb.sv
// Self-checking bench for the basic control and status bank.
// Assumes straps stay fixed; only negotiated duplex moves mid-run.
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, reset = 1'b1, reg_write, reg_read, reg_hit, h;
    logic [4:0] reg_index;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic speed_strap = 1'b1, autoneg_enable_strap = 1'b0, isolate_strap = 1'b1;
    logic duplex_strap = 1'b0, aneg_speed_100 = 1'b0, aneg_full_duplex = 1'b0;
    logic soft_reset_pulse, aneg_restart_pulse, loopback, isolate, collision_test;
    logic power_down, autoneg_enable, speed_100, full_duplex;
    int errors = 0, comparisons = 0;
    pbc_regs DUT (.*);
    pbc_mgmt_model mgr (.*);
    // Free-running 50 MHz clock
    always #10 clk = ~clk;
    // Compare and count
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Single exit point
    task automatic wrap_up;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // Hang guard
    initial begin
        repeat (2000) @(posedge clk);
        errors++;
        wrap_up();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        #1 reset = 1'b0;
        repeat (3) @(posedge clk);
        mgr.rd(5'h00, d, h);
        chk("ctl_default", d, 16'h2500);
        chk("hit_ctl", {15'h0, h}, 16'h0001);
        chk("strap_out", {13'h0, speed_100, isolate, full_duplex}, 16'h0007);
        mgr.rd(5'h01, d, h);
        chk("status", d, 16'h7849);
        mgr.rd(5'h10, d, h);
        chk("vendor_rd", d, 16'h0000);
        chk("vendor_hit", {15'h0, h}, 16'h0000);
        $display("test reset_status done");
        mgr.wr(5'h00, 16'h63FF);
        chk("restart", {15'h0, aneg_restart_pulse}, 16'h0001);
        chk("modes", {13'h0, loopback, isolate, collision_test}, 16'h0005);
        @(posedge clk);
        #1 chk("restart_clr", {15'h0, aneg_restart_pulse}, 16'h0000);
        mgr.wr(5'h05, 16'h0000);
        mgr.rd(5'h00, d, h);
        chk("ctl_rw", d, 16'h6180);
        chk("fixed_mode", {14'h0, speed_100, full_duplex}, 16'h0003);
        aneg_full_duplex = 1'b1;
        mgr.wr(5'h00, 16'h3000);
        repeat (2) @(posedge clk);
        #1 chk("aneg_mode", {13'h0, autoneg_enable, speed_100, full_duplex}, 16'h0005);
        $display("test control_write done");
        mgr.wr(5'h00, 16'h0800);
        chk("pdown_on", {15'h0, power_down}, 16'h0001);
        mgr.wr(5'h00, 16'h8000);
        chk("pdown_off", {14'h0, power_down, soft_reset_pulse}, 16'h0000);
        mgr.wr(5'h00, 16'h8000);
        chk("sw_reset", {15'h0, soft_reset_pulse}, 16'h0001);
        repeat (3) @(posedge clk);
        mgr.rd(5'h00, d, h);
        chk("ctl_restrap", d, 16'h2500);
        $display("test power_down done");
        wrap_up();
    end
endmodule : tb
